/* bce_pkg.sv */
// Purpose: constants for the bridge control and express capability registers
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets, reset values and most field positions live here; checks repeat some as literals
package bce_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CAP_HDR = 8'h40;
  localparam logic [7:0] OFF_DEV_CAP = 8'h44;
  localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h48;
  localparam logic [7:0] OFF_LOCK_CTRL = 8'h4c;

  // bridge control bit positions
  localparam int BC_VGA_FWD = 3;
  localparam int BC_VGA_WIDE = 4;
  localparam int BC_SEC_RST = 6;

  // capability header field positions
  localparam int CH_NXT_LSB = 8;
  localparam int CH_VER_LSB = 16;
  localparam int CH_TYPE_LSB = 20;
  localparam int CH_SLOT = 24;
  localparam int CH_TCS = 30;

  // capability header constant and reset values
  localparam logic [7:0] CAP_ID_VAL = 8'h10;
  localparam logic [7:0] NXT_PTR_RST = 8'hc0;
  localparam logic [3:0] CAP_VER_RST = 4'h1;
  localparam logic [3:0] TYPE_UPSTREAM = 4'h5;
  localparam logic [3:0] TYPE_DOWNSTREAM = 4'h6;
  localparam logic SLOT_RST = 1'b0;
  localparam logic TCS_RST = 1'b1;
  localparam logic TCS_RST_V11 = 1'b0;
  localparam logic [4:0] IMN_VAL = 5'h00;

  // bridge control and lock permit reset values
  localparam logic BC_BIT_RST = 1'b0;
  localparam logic LOCK_PERMIT_RST = 1'b0;

  // cycles after reset before straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // vga compatible i/o ranges, low ten address bits
  localparam logic [9:0] VGA_LO0 = 10'h3b0;
  localparam logic [9:0] VGA_HI0 = 10'h3bb;
  localparam logic [9:0] VGA_LO1 = 10'h3c0;
  localparam logic [9:0] VGA_HI1 = 10'h3df;

  // defaults loaded or not yet
  typedef enum logic {
    INIT_WAIT = 1'b0,
    INIT_RUN = 1'b1
  } bce_init_e;

endpackage

/* bce_vga_decode.sv */
// Purpose: match an i/o address against the vga compatible ranges
// Assumes: combinational, caller registers the result
// Notes: 10-bit mode matches every alias of the ranges
`timescale 1ns/1ps
module bce_vga_decode (
  // i/o address under test
  input wire logic [15:0] io_addr,
  // bridge control fields
  input wire logic fwd_en,
  input wire logic wide_sel,
  // forward decision
  output logic hit
);

  logic in_range; // low ten bits inside a vga range
  logic upper_ok; // upper bits acceptable for the decode width

  // range compare on the low ten bits only
  always_comb begin
    in_range = ((io_addr[9:0] >= bce_pkg::VGA_LO0) && (io_addr[9:0] <= bce_pkg::VGA_HI0)) ||
               ((io_addr[9:0] >= bce_pkg::VGA_LO1) && (io_addr[9:0] <= bce_pkg::VGA_HI1));
  end

  // wide decode also wants bits 15:10 clear, so no aliases
  always_comb begin
    upper_ok = !wide_sel || (io_addr[15:10] == 6'h00);
  end

  // width select only matters once forwarding is on
  always_comb begin
    hit = fwd_en && in_range && upper_ok;
  end

endmodule

/* bce_regs.sv */
// Purpose: bridge control upper bits and express capability header over apb
// Assumes: straps come from pins, i/o requests from logic on pclk
// Notes: no wait states on any apb access, lock fields need permit bit
`timescale 1ns/1ps

// Notes on behaviour
// - wide select matters only with forwarding on
// - narrow decode matches aliases, wide does not
// - secondary reset bit drives port reset
// - capability identifier reads fixed 0x10
// - next pointer resets 0xc0, lock writable
// - version resets 0x1, lock writable
// - port type 0x5 upstream, 0x6 downstream
// - slot flag resets zero, lock writable on either port type
// - interrupt message number reads zero
// - tcs flag lock writable, mode dependent default
// - forward enable passes or blocks vga addresses
module bce_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps from pins
  input wire logic upstream_port_strap,
  input wire logic pcie11_mode_strap,
  // i/o request to check for vga forwarding
  input wire logic io_req_valid,
  input wire logic [15:0] io_req_addr,
  // port outputs
  output logic vga_forward_q,
  output logic sec_bus_reset_q,
  output logic upstream_sec_reset_q
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0] strap_s1_q; // first sync stage, read by stage two only
  logic [1:0] strap_s2_q; // second sync stage
  logic [1:0] strap_s3_q; // third sync stage
  logic [1:0] strap_q; // filtered straps, bit1 upstream, bit0 v1.1
  logic [1:0] strap_d; // filtered straps as accepted at this edge
  logic [1:0] settle_q; // cycles since reset release
  bce_pkg::bce_init_e init_q; // defaults loaded state
  logic vga_fwd_en_q; // vga_forward_enable
  logic vga_wide_q; // vga_wide_decode_select
  logic sec_rst_q; // secondary_bus_reset_trigger
  logic [7:0] nxt_ptr_q; // next_capability_pointer
  logic [3:0] cap_ver_q; // capability_version
  logic slot_q; // slot implemented
  logic tcs_q; // traffic_class_routing_supported
  logic lock_permit_q; // lock_writable permit
  logic [3:0] port_type; // derived port type
  logic addr_ok; // mapped address
  logic wr_en; // write completes this edge
  logic lock_wr; // lock field write allowed
  logic [31:0] rdata_d; // read mux
  logic vga_hit; // decoder result

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  // three flop sync on the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      strap_s3_q <= 2'h0;
    end else begin
      strap_s1_q <= {upstream_port_strap, pcie11_mode_strap};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  // accept a strap change once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= 2'h0;
    end else begin
      strap_q <= strap_d;
    end
  end

  // wait for the sync chain to fill before loading defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 2'h0;
      init_q <= bce_pkg::INIT_WAIT;
    end else if (settle_q != bce_pkg::STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end else begin
      init_q <= bce_pkg::INIT_RUN;
    end
  end

  // next filtered strap, so the last default load sees a settled strap
  // port type follows the upstream strap
  always_comb begin
    strap_d = (strap_s2_q == strap_s3_q) ? strap_s3_q : strap_q;
    port_type = strap_q[1] ? bce_pkg::TYPE_UPSTREAM : bce_pkg::TYPE_DOWNSTREAM;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake

  // decode, completion and lock qualifier
  always_comb begin
    addr_ok = (paddr == bce_pkg::OFF_CAP_HDR) || (paddr == bce_pkg::OFF_DEV_CAP) ||
              (paddr == bce_pkg::OFF_BRIDGE_CTRL) || (paddr == bce_pkg::OFF_LOCK_CTRL);
    wr_en = psel && penable && pready && pwrite && !pslverr;
    lock_wr = wr_en && lock_permit_q && (init_q == bce_pkg::INIT_RUN);
  end

  // ready in the access phase, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      bce_pkg::OFF_CAP_HDR: begin
        rdata_d[7:0] = bce_pkg::CAP_ID_VAL;
        rdata_d[bce_pkg::CH_NXT_LSB +: 8] = nxt_ptr_q;
        rdata_d[bce_pkg::CH_VER_LSB +: 4] = cap_ver_q;
        rdata_d[bce_pkg::CH_TYPE_LSB +: 4] = port_type;
        rdata_d[bce_pkg::CH_SLOT] = slot_q;
        rdata_d[29:25] = bce_pkg::IMN_VAL;
        rdata_d[bce_pkg::CH_TCS] = tcs_q;
      end
      bce_pkg::OFF_BRIDGE_CTRL: begin
        rdata_d[bce_pkg::BC_VGA_FWD] = vga_fwd_en_q;
        rdata_d[bce_pkg::BC_VGA_WIDE] = vga_wide_q;
        rdata_d[bce_pkg::BC_SEC_RST] = sec_rst_q;
      end
      bce_pkg::OFF_LOCK_CTRL: begin
        rdata_d[0] = lock_permit_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridge control and lock registers

  // plain read/write bits in byte lane zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vga_fwd_en_q <= bce_pkg::BC_BIT_RST;
      vga_wide_q <= bce_pkg::BC_BIT_RST;
      sec_rst_q <= bce_pkg::BC_BIT_RST;
    end else if (wr_en && pstrb[0] && (paddr == bce_pkg::OFF_BRIDGE_CTRL)) begin
      vga_fwd_en_q <= pwdata[bce_pkg::BC_VGA_FWD];
      vga_wide_q <= pwdata[bce_pkg::BC_VGA_WIDE];
      sec_rst_q <= pwdata[bce_pkg::BC_SEC_RST];
    end
  end

  // lock permit, governs all lock writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_permit_q <= bce_pkg::LOCK_PERMIT_RST;
    end else if (wr_en && pstrb[0] && (paddr == bce_pkg::OFF_LOCK_CTRL)) begin
      lock_permit_q <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capability header lock writable fields

  // defaults once straps settle, then writes under permit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nxt_ptr_q <= bce_pkg::NXT_PTR_RST;
      cap_ver_q <= bce_pkg::CAP_VER_RST;
      slot_q <= bce_pkg::SLOT_RST;
      tcs_q <= bce_pkg::TCS_RST;
    end else if (init_q == bce_pkg::INIT_WAIT) begin
      // tcs default depends on the v1.1 strap
      tcs_q <= strap_d[0] ? bce_pkg::TCS_RST_V11 : bce_pkg::TCS_RST;
      slot_q <= bce_pkg::SLOT_RST;
    end else if (lock_wr && (paddr == bce_pkg::OFF_CAP_HDR)) begin
      if (pstrb[1]) begin
        nxt_ptr_q <= pwdata[bce_pkg::CH_NXT_LSB +: 8];
      end
      if (pstrb[2]) begin
        cap_ver_q <= pwdata[bce_pkg::CH_VER_LSB +: 4];
      end
      if (pstrb[3]) begin
        slot_q <= pwdata[bce_pkg::CH_SLOT];
        tcs_q <= pwdata[bce_pkg::CH_TCS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port behaviour

  bce_vga_decode u_vga_decode (
    .io_addr(io_req_addr),
    .fwd_en(vga_fwd_en_q),
    .wide_sel(vga_wide_q),
    .hit(vga_hit)
  );

  // forward decision for the presented i/o address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vga_forward_q <= 1'b0;
    end else begin
      vga_forward_q <= io_req_valid && vga_hit;
    end
  end

  // reset request steered by port type
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_bus_reset_q <= 1'b0;
      upstream_sec_reset_q <= 1'b0;
    end else begin
      sec_bus_reset_q <= sec_rst_q && !strap_q[1];
      upstream_sec_reset_q <= sec_rst_q && strap_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // forwarding off blocks every address
  property p_fwd_off_blocks;
    (io_req_valid && !vga_fwd_en_q) |=> !vga_forward_q;
  endproperty
  a_fwd_off_blocks: assert property (p_fwd_off_blocks)
    else $error("vga forwarded while forward enable clear");

  // narrow decode matches an alias of 0x3c0
  property p_narrow_alias;
    (io_req_valid && vga_fwd_en_q && !vga_wide_q && io_req_addr[9:0] == 10'h3c0)
      |=> vga_forward_q;
  endproperty
  a_narrow_alias: assert property (p_narrow_alias)
    else $error("narrow decode missed a vga alias");

  // wide decode rejects aliases
  property p_wide_no_alias;
    (io_req_valid && vga_wide_q && io_req_addr[15:10] != 6'h00) |=> !vga_forward_q;
  endproperty
  a_wide_no_alias: assert property (p_wide_no_alias)
    else $error("wide decode matched an alias");

  // reset bit written reaches exactly one reset output two edges later
  property p_sec_reset;
    (wr_en && pstrb[0] && paddr == bce_pkg::OFF_BRIDGE_CTRL && pwdata[bce_pkg::BC_SEC_RST])
      |-> ##2 (sec_bus_reset_q != upstream_sec_reset_q);
  endproperty
  a_sec_reset: assert property (p_sec_reset)
    else $error("secondary reset not raised after write");

  // header read returns identifier, zero message number and zero bit 31
  property p_hdr_read;
    (psel && penable && pready && !pwrite && !pslverr && paddr == bce_pkg::OFF_CAP_HDR)
      |-> (prdata[7:0] == 8'h10 && prdata[29:25] == 5'h00 && prdata[31] == 1'b0);
  endproperty
  a_hdr_read: assert property (p_hdr_read)
    else $error("capability header constant fields wrong");

  // port type matches the filtered strap
  property p_port_type;
    (psel && penable && pready && !pwrite && paddr == bce_pkg::OFF_CAP_HDR)
      |-> (prdata[23:20] == (strap_q[1] ? 4'h5 : 4'h6));
  endproperty
  a_port_type: assert property (p_port_type)
    else $error("port type does not match strap");

  // next pointer, version and tcs change only by a permitted write
  property p_lock_hold;
    ((init_q == bce_pkg::INIT_RUN) && !$past(lock_wr) && $past(init_q) == bce_pkg::INIT_RUN)
      |-> ($stable(nxt_ptr_q) && $stable(cap_ver_q) && $stable(tcs_q));
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock writable field changed without permit");

  // defaults hold when software has not yet written
  property p_defaults;
    (init_q == bce_pkg::INIT_WAIT) ##1 (init_q == bce_pkg::INIT_RUN)
      |-> (nxt_ptr_q == 8'hc0 && cap_ver_q == 4'h1 && tcs_q == !strap_q[0] && !slot_q);
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("capability defaults wrong after strap load");

  // reserved bridge control bits 31:7 and 5 read zero
  property p_bc_reserved;
    (psel && penable && pready && !pwrite && paddr == bce_pkg::OFF_BRIDGE_CTRL)
      |-> (prdata[31:7] == 25'h0 && prdata[5] == 1'b0);
  endproperty
  a_bc_reserved: assert property (p_bc_reserved)
    else $error("reserved bridge control bits not zero");

  // main scenarios
  c_vga_fwd: cover property (io_req_valid && vga_fwd_en_q ##1 vga_forward_q);
  c_lock_write: cover property (lock_wr && paddr == bce_pkg::OFF_CAP_HDR);
  c_sec_reset: cover property (sec_rst_q ##2 sec_bus_reset_q);
  c_unmapped: cover property (pslverr && pready);

endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the bridge control and express capability registers
// Assumes: apb answers by pready, straps reload only through a reset
// Notes: scenarios are tasks except the upstream check; expectations mix package constants and literals
`timescale 1ns/1ps
module tb_top;
  // clock, reset and apb
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  // straps and vga request
  logic upstream_port_strap, pcie11_mode_strap, io_req_valid;
  logic [15:0] io_req_addr;
  // port outputs
  logic vga_forward_q, sec_bus_reset_q, upstream_sec_reset_q;
  logic err;
  int n_errors, total_checks, cycles;

  bce_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upstream_port_strap(upstream_port_strap),
    .pcie11_mode_strap(pcie11_mode_strap), .io_req_valid(io_req_valid),
    .io_req_addr(io_req_addr), .vga_forward_q(vga_forward_q),
    .sec_bus_reset_q(sec_bus_reset_q), .upstream_sec_reset_q(upstream_sec_reset_q));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // reset with given straps, then let strap defaults load
  task automatic do_reset(input logic up, input logic v11);
    @(posedge pclk);
    presetn <= 1'b0;
    upstream_port_strap <= up;
    pcie11_mode_strap <= v11;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected capability header word
  function automatic logic [31:0] hdr(input logic [3:0] typ, input logic traffic_class_routing_supported,
    input logic slot, input logic [3:0] capability_version, input logic [7:0] nxt);
    hdr = {1'b0, traffic_class_routing_supported, 5'h00, slot, typ, capability_version, nxt, bce_pkg::CAP_ID_VAL};
  endfunction

  // one vga request, decision checked the cycle after capture
  task automatic vga(input logic [15:0] a, input logic exp);
    @(posedge pclk);
    io_req_valid <= 1'b1;
    io_req_addr <= a;
    @(posedge pclk);
    io_req_valid <= 1'b0;
    @(posedge pclk);
    chk("vga_forward_q", {31'h0, vga_forward_q}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  // reset values of a downstream port in normal mode
  task automatic t_reset_values();
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr", rd, hdr(bce_pkg::TYPE_DOWNSTREAM, 1'b1, 1'b0, 4'h1, 8'hc0));
    apb(1'b0, bce_pkg::OFF_BRIDGE_CTRL, 32'h0);
    chk("bridge_ctrl", rd, 32'h0);
    apb(1'b0, bce_pkg::OFF_DEV_CAP, 32'h0);
    chk("dev_cap", rd, 32'h0);
  endtask

  // byte strobes: only the lanes that are set take the write
  task automatic t_strobe();
    pstrb <= 4'h2;
    apb(1'b1, bce_pkg::OFF_CAP_HDR, 32'hffffffff);
    pstrb <= 4'he;
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'hffffffff);
    pstrb <= 4'hf;
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr_lane1", rd, hdr(4'h6, 1'b0, 1'b0, 4'h0, 8'hff));
    apb(1'b0, bce_pkg::OFF_BRIDGE_CTRL, 32'h0);
    chk("bridge_lane0_off", rd, 32'h0);
  endtask

  // lock fields ignore writes until permitted, read-only fields never move
  task automatic t_lock();
    apb(1'b1, bce_pkg::OFF_CAP_HDR, 32'hffffffff);
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr_locked", rd, hdr(4'h6, 1'b1, 1'b0, 4'h1, 8'hc0));
    apb(1'b1, bce_pkg::OFF_LOCK_CTRL, 32'h1);
    apb(1'b1, bce_pkg::OFF_CAP_HDR, 32'hffffffff);
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr_ones", rd, hdr(4'h6, 1'b1, 1'b1, 4'hf, 8'hff));
    apb(1'b1, bce_pkg::OFF_CAP_HDR, 32'h0);
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr_zero", rd, hdr(4'h6, 1'b0, 1'b0, 4'h0, 8'h00));
  endtask

  // reserved bridge bits and secondary reset routing
  task automatic t_bridge(input logic up);
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'hffffffff);
    apb(1'b0, bce_pkg::OFF_BRIDGE_CTRL, 32'h0);
    chk("bridge_ones", rd, 32'h00000058);
    repeat (2) @(posedge pclk);
    chk("sec_reset", {31'h0, sec_bus_reset_q}, {31'h0, ~up});
    chk("up_sec_reset", {31'h0, upstream_sec_reset_q}, {31'h0, up});
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("sec_reset_off", {30'h0, sec_bus_reset_q, upstream_sec_reset_q}, 32'h0);
  endtask

  // forwarding off, narrow with aliases, wide without
  task automatic t_vga();
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'h00000010);
    vga(16'h03c0, 1'b0);
    vga(16'h07c0, 1'b0);
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'h00000008);
    vga(16'h03bb, 1'b1);
    vga(16'h07c0, 1'b1);
    vga(16'h03bc, 1'b0);
    vga(16'h03df, 1'b1);
    apb(1'b1, bce_pkg::OFF_BRIDGE_CTRL, 32'h00000018);
    vga(16'h07c0, 1'b0);
    vga(16'h03b0, 1'b1);
  endtask

  // unmapped address errors and reads zero
  task automatic t_unmapped();
    apb(1'b1, 8'h50, 32'hffffffff);
    chk("err_wr", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h50, 32'h0);
    chk("err_rd", {31'h0, err}, 32'h1);
    chk("rd_unmapped", rd, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    upstream_port_strap = 1'b0;
    pcie11_mode_strap = 1'b0;
    io_req_valid = 1'b0;
    io_req_addr = 16'h0000;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    do_reset(1'b0, 1'b0);
    t_reset_values();
    t_lock();
    t_strobe();
    t_bridge(1'b0);
    t_vga();
    t_unmapped();
    // upstream port in v1.1 mode
    do_reset(1'b1, 1'b1);
    apb(1'b0, bce_pkg::OFF_CAP_HDR, 32'h0);
    chk("cap_hdr_up", rd, hdr(bce_pkg::TYPE_UPSTREAM, 1'b0, 1'b0, 4'h1, 8'hc0));
    t_bridge(1'b1);
    conclude();
  end
endmodule
